// ---- rtl/bank_eeprom_consts.svh ----
/*
 * Constants for the data bank select and EEPROM control block.
 * Assumes an 8-bit data space with byte-wide accesses.
 */
`ifndef BANK_EEPROM_CONSTS_SVH
`define BANK_EEPROM_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_DATA_BANK_SELECT  8'hcb
`define ADDR_EEPROM_CONTROL    8'hdf
`define WINDOW_TOP             8'h3f

// ----------------------------------------------------------------
// Bank select fields
// ----------------------------------------------------------------
`define BANK_EE_PAGE0          3'd0
`define BANK_EE_PAGE1          3'd1
`define BANK_RAM_PAGE1         3'd3
`define BANK_RAM_PAGE2         3'd4
`define BANK_LCD_PAGE2         3'd5
`define BANK_LCD_PAGE1         3'd6

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_ENABLE             3'd0
`define CTL_BUSY               3'd1
`define CTL_PAR_MODE           3'd2
`define CTL_PAR_START          3'd3
`define CTL_STANDBY            3'd6
`define CTL_RESET              8'h00
// Reserved control bits 5:4 are kept clear on every write
`define CTL_RSVD_MASK          8'hcf

// ----------------------------------------------------------------
// Timing: programming time in us and its cycle count at 100 MHz
// ----------------------------------------------------------------
`define PROG_TIME_US           20
`define CLK_MHZ                100
`define PROG_CYCLES            (`PROG_TIME_US * `CLK_MHZ)
`define PROG_CNT_W             16

`endif

// ---- rtl/bank_eeprom_pkg.sv ----
/*
 * Types used by the device-side end only; the CPU-side end does not import them.
 * Assumes bank_eeprom_consts.svh for all numbers.
 */
package bank_eeprom_pkg;
	typedef enum logic [1:0] {
		st_idle  = 2'b00,
		st_byte  = 2'b01,
		st_row   = 2'b10
	} prog_state_t;
endpackage : bank_eeprom_pkg

// ---- rtl/data_bus_if.sv ----
/*
 * Data-space bus between the CPU end and the paging/EEPROM end.
 * Assumes one clock; read data answer one cycle after the read strobe, two cycles for RAM/LCD page reads.
 */
`timescale 1ns/10ps
interface data_bus_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       rvalid;
	modport cpu (output addr, output wdata, output wr, output rd, input rdata, input rvalid);
	modport dev (input addr, input wdata, input wr, input rd, output rdata, output rvalid);
endinterface : data_bus_if

// ---- rtl/bank_eeprom_dev.sv ----
/*
 * Data bank select register, paged window routing and EEPROM control
 * with byte and row programming, over a 128-byte EEPROM array.
 * Assumes the CPU end on the data_bus_if and external RAM/LCD arrays
 * reached through the page strobes on the user side.
 */
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`include "bank_eeprom_consts.svh"
// How it works
// R1: bank bits select EEPROM, RAM, LCD pages
// R2: window 00h-3Fh routed to selected page
// R3: bank register write-only, reads return nothing
// R4: bank register undefined; software writes first
// R5: selection untouched by interrupts or calls
// R6: software sets at most one bank bit
// R7: software avoids bank changes in handlers
// R8: EEPROM access meaningless if unselected/standby
// R9: bit 6 standby disables EEPROM
// R10: write without enable starts nothing
// R11: busy aborts accesses, cycle completes
// R12: control writes ignored while busy
// R13: idle EEPROM reads like plain data
// R14: byte mode writes byte directly
// R15: parallel mode clears latches, latches row
// R16: row fixed until cycle ends or cleared
// R17: start programs only written row bytes
// R18: cycle end clears mode and start
// R19: start needs enable and parallel mode
// R20: clearing mode discards latched data
// R21: software keeps bits 4,5 zero
// R22: busy held fixed time then cleared
module bank_eeprom_dev (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// CPU data bus
	data_bus_if.dev         bus,
	// Banked RAM and LCD arrays outside
	output logic [3:0]      page_sel,
	output logic [5:0]      page_addr,
	output logic [7:0]      page_wdata,
	output logic            page_wr,
	output logic            page_rd,
	input  wire logic [7:0] page_rdata,
	// Status
	output logic            prog_busy
);
	typedef struct packed {
		logic [7:0]                 bank;
		logic                       standby;
		logic                       enable;
		logic                       par_mode;
		logic                       par_start;
		logic                       row_valid;
		logic [3:0]                 row;
		logic [7:0]                 row_used;
		logic [63:0]                latch;
		logic [6:0]                 byte_addr;
		logic [7:0]                 byte_data;
		logic [`PROG_CNT_W-1:0]     cnt;
		bank_eeprom_pkg::prog_state_t st;
		logic [7:0]                 rdata;
		logic                       rvalid;
		logic                       ext_pend;
		logic [3:0]                 page_sel;
		logic [5:0]                 page_addr;
		logic [7:0]                 page_wdata;
		logic                       page_wr;
		logic                       page_rd;
		logic                       busy;
	} state_t;

	state_t     cur;
	state_t     nxt;
	logic [7:0] mem [0:127];
	logic       mem_we;
	logic [6:0] mem_wa;
	logic [7:0] mem_wd;

	function automatic logic in_window(input logic [7:0] a);
		in_window = (a <= `WINDOW_TOP);
	endfunction : in_window

	function automatic logic [6:0] ee_index(input logic [7:0] b, input logic [5:0] a);
		ee_index = {b[`BANK_EE_PAGE1], a};
	endfunction : ee_index

	always_comb begin
		logic ee_sel;
		logic ee_ok;
		logic [7:0] w;
		ee_sel = 1'b0;
		ee_ok = 1'b0;
		w = bus.wdata;
		nxt = cur;
		nxt.rvalid = 1'b0;
		nxt.rdata = 8'h00;
		nxt.page_wr = 1'b0;
		nxt.page_rd = 1'b0;
		mem_we = 1'b0;
		mem_wa = 7'h00;
		mem_wd = 8'h00;
		// R1: decode EEPROM pages
		ee_sel = cur.bank[`BANK_EE_PAGE0] | cur.bank[`BANK_EE_PAGE1];
		// R8: standby or unselected makes it void
		// R11: busy aborts access
		ee_ok = ee_sel && !cur.standby && (cur.st == bank_eeprom_pkg::st_idle);
		// Read data from the external arrays land one cycle after their strobe
		if (cur.ext_pend) begin
			nxt.rdata = page_rdata;
		end
		nxt.ext_pend = 1'b0;
		if (bus.wr) begin
			// R3: bank register is written only
			// R5: nothing but this write alters it
			if (bus.addr == `ADDR_DATA_BANK_SELECT) begin
				nxt.bank = w;
			end
			// R12: control ignored while busy
			if (bus.addr == `ADDR_EEPROM_CONTROL && cur.st == bank_eeprom_pkg::st_idle) begin
				// R9: standby bit
				nxt.standby = w[`CTL_STANDBY];
				nxt.enable = w[`CTL_ENABLE];
				// R15: rising parallel mode clears latches
				if (w[`CTL_PAR_MODE] && !cur.par_mode) begin
					nxt.latch = '0;
					nxt.row_used = 8'h00;
					nxt.row_valid = 1'b0;
				end
				// R20: clearing mode discards latched row
				if (!w[`CTL_PAR_MODE]) begin
					nxt.row_used = 8'h00;
					nxt.row_valid = 1'b0;
				end
				nxt.par_mode = w[`CTL_PAR_MODE];
				// R19: start only with enable and mode
				if (w[`CTL_PAR_START] && w[`CTL_ENABLE] && w[`CTL_PAR_MODE] && cur.par_mode
					&& cur.row_valid) begin
					nxt.par_start = 1'b1;
					nxt.st = bank_eeprom_pkg::st_row;
					nxt.cnt = '0;
				end
			end
			// R2: window routing on write
			if (in_window(bus.addr)) begin
				if (ee_sel) begin
					// R10: no enable, no programming
					if (ee_ok && cur.enable) begin
						if (cur.par_mode) begin
							// R16: other rows ignored once latched
							if (!cur.row_valid || cur.row == {cur.bank[`BANK_EE_PAGE1],
								bus.addr[5:3]}) begin
								nxt.latch[{bus.addr[2:0], 3'b000} +: 8] = w;
								nxt.row_valid = 1'b1;
								nxt.row = {cur.bank[`BANK_EE_PAGE1], bus.addr[5:3]};
								nxt.row_used[bus.addr[2:0]] = 1'b1;
							end
						end else begin
							// R14: byte written straight through
							nxt.byte_addr = ee_index(cur.bank, bus.addr[5:0]);
							nxt.byte_data = w;
							nxt.st = bank_eeprom_pkg::st_byte;
							nxt.cnt = '0;
						end
					end
				end else if (cur.bank[6:3] != 4'h0) begin
					nxt.page_wr = 1'b1;
					nxt.page_addr = bus.addr[5:0];
					nxt.page_wdata = w;
				end
			end
		end
		if (bus.rd) begin
			nxt.rvalid = 1'b1;
			if (bus.addr == `ADDR_EEPROM_CONTROL) begin
				nxt.rdata[`CTL_BUSY] = (cur.st != bank_eeprom_pkg::st_idle);
			end else if (in_window(bus.addr)) begin
				// R13: plain one-cycle read when idle
				if (ee_sel) begin
					if (ee_ok) begin
						nxt.rdata = mem[ee_index(cur.bank, bus.addr[5:0])];
					end
				end else if (cur.bank[6:3] != 4'h0) begin
					nxt.page_rd = 1'b1;
					nxt.page_addr = bus.addr[5:0];
					nxt.ext_pend = 1'b1;
					nxt.rvalid = 1'b0;
				end
			end
		end
		if (cur.ext_pend) begin
			nxt.rvalid = 1'b1;
		end
		nxt.page_sel = {cur.bank[`BANK_LCD_PAGE1], cur.bank[`BANK_LCD_PAGE2],
			cur.bank[`BANK_RAM_PAGE2], cur.bank[`BANK_RAM_PAGE1]};
		// R22: fixed programming time
		if (cur.st != bank_eeprom_pkg::st_idle) begin
			nxt.cnt = cur.cnt + 1'b1;
			if (cur.cnt == `PROG_CNT_W'(`PROG_CYCLES - 1)) begin
				nxt.st = bank_eeprom_pkg::st_idle;
				nxt.cnt = '0;
				if (cur.st == bank_eeprom_pkg::st_byte) begin
					mem_we = 1'b1;
					mem_wa = cur.byte_addr;
					mem_wd = cur.byte_data;
				end else begin
					// R18: end clears mode and start
					nxt.par_mode = 1'b0;
					nxt.par_start = 1'b0;
					nxt.row_valid = 1'b0;
					nxt.row_used = 8'h00;
				end
			end
		end
		// Busy comes from a flop so the status pin is glitch free
		nxt.busy = (nxt.st != bank_eeprom_pkg::st_idle);
	end

	// R4: bank register reset to no page in hardware; software still writes it first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
		end else begin
			cur <= nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
		// R17: only written row bytes change
		if (cur.st == bank_eeprom_pkg::st_row && cur.cnt == `PROG_CNT_W'(`PROG_CYCLES - 1)) begin
			for (int i = 0; i < 8; i++) begin
				if (cur.row_used[i]) begin
					mem[{cur.row, 3'(i)}] <= cur.latch[i*8 +: 8];
				end
			end
		end
	end

	assign bus.rdata    = cur.rdata;
	assign bus.rvalid   = cur.rvalid;
	assign page_sel     = cur.page_sel;
	assign page_addr    = cur.page_addr;
	assign page_wdata   = cur.page_wdata;
	assign page_wr      = cur.page_wr;
	assign page_rd      = cur.page_rd;
	assign prog_busy    = cur.busy;
endmodule : bank_eeprom_dev

// ---- rtl/bank_eeprom_cpu.sv ----
/*
 * CPU-side end: turns plain software register port commands into
 * data-space accesses, keeping shadow copies of write-only registers.
 * Assumes the device end on data_bus_if.
 */
`timescale 1ns/10ps
`include "bank_eeprom_consts.svh"
module bank_eeprom_cpu (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Software port
	input  wire logic [7:0] sw_addr,
	input  wire logic [7:0] sw_wdata,
	input  wire logic       sw_wr,
	input  wire logic       sw_rd,
	output logic [7:0]      sw_rdata,
	// Shadow copies of write-only registers
	output logic [7:0]      bank_copy,
	output logic [7:0]      ctl_copy,
	// Data bus
	data_bus_if.cpu         bus
);
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
		logic [7:0] rdata;
		logic [7:0] bank_copy;
		logic [7:0] ctl_copy;
	} state_t;

	state_t cur;
	state_t nxt;

	always_comb begin
		nxt = cur;
		nxt.wr = sw_wr;
		nxt.rd = sw_rd;
		nxt.addr = sw_addr;
		nxt.wdata = sw_wdata;
		// R7: image kept alongside each write
		if (sw_wr && sw_addr == `ADDR_DATA_BANK_SELECT) begin
			nxt.bank_copy = sw_wdata;
		end
		// R21: bits 4 and 5 forced to zero
		if (sw_wr && sw_addr == `ADDR_EEPROM_CONTROL) begin
			nxt.wdata = sw_wdata & `CTL_RSVD_MASK;
			nxt.ctl_copy = sw_wdata & `CTL_RSVD_MASK;
		end
		// R6: only the lowest requested bank bit passes
		if (sw_wr && sw_addr == `ADDR_DATA_BANK_SELECT) begin
			nxt.wdata = sw_wdata & (~sw_wdata + 8'h01);
			nxt.bank_copy = nxt.wdata;
		end
		if (bus.rvalid) begin
			nxt.rdata = bus.rdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
		end else begin
			cur <= nxt;
		end
	end

	assign bus.addr  = cur.addr;
	assign bus.wdata = cur.wdata;
	assign bus.wr    = cur.wr;
	assign bus.rd    = cur.rd;
	assign sw_rdata  = cur.rdata;
	assign bank_copy = cur.bank_copy;
	assign ctl_copy  = cur.ctl_copy;
endmodule : bank_eeprom_cpu

// ---- bench/bank_eeprom_checker.sv ----
/* Checker on the bus joining the two ends, plus device status outputs.
 * Assumes tb_top instantiates it beside data_bus_if, one clock domain. */
`timescale 1ns/10ps
`include "bank_eeprom_consts.svh"
module bank_eeprom_checker (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// Data bus
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       rvalid,
	// Device user side
	input wire logic [3:0] page_sel,
	input wire logic [5:0] page_addr,
	input wire logic [7:0] page_wdata,
	input wire logic       page_wr,
	input wire logic       page_rd,
	input wire logic       prog_busy
);
	localparam int PROG = `PROG_CYCLES;
	// ------------------------------------------------------------
	// Helper state
	// ------------------------------------------------------------
	logic [15:0] busy_len;
	logic        en_seen;
	logic [7:0]  wd_q;
	logic [7:0]  addr_q;
	logic [7:0]  bank_q;
	// Enable copy ignores writes while busy, as the device does
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_len <= 16'h0000;
			en_seen  <= 1'b0;
			wd_q     <= 8'h00;
			addr_q   <= 8'h00;
			bank_q   <= 8'h00;
		end else begin
			busy_len <= prog_busy ? busy_len + 16'h0001 : 16'h0000;
			wd_q     <= wdata;
			addr_q   <= addr;
			if (wr && addr == `ADDR_DATA_BANK_SELECT)
				bank_q <= wdata;
			if (wr && addr == `ADDR_EEPROM_CONTROL && !prog_busy)
				en_seen <= wdata[0];
		end
	end
	default clocking cb_clk @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	// Page pins follow the bank one cycle after the register takes it
	a_page_map: assert property (wr && addr == `ADDR_DATA_BANK_SELECT |=> ##1
		page_sel == bank_q[6:3])
		else $error("page select does not follow bank write");
	a_bank_steady: assert property (!(wr && addr == `ADDR_DATA_BANK_SELECT)
		&& !$past(wr && addr == `ADDR_DATA_BANK_SELECT) |=> $stable(page_sel))
		else $error("page select moved without a bank write");
	a_window_route: assert property (wr && addr <= `WINDOW_TOP && page_sel != 4'h0
		|=> page_wr && page_addr == addr_q[5:0] && page_wdata == wd_q)
		else $error("window write not routed");
	a_window_read: assert property (rd && addr <= `WINDOW_TOP && page_sel != 4'h0
		|=> page_rd && page_addr == addr_q[5:0]) else $error("window read not routed");
	a_ctl_reserved: assert property (wr && addr == `ADDR_EEPROM_CONTROL
		|-> wdata[5:4] == 2'b00) else $error("reserved control bits written");
	a_ctl_read: assert property (rd && addr == `ADDR_EEPROM_CONTROL |=>
		rvalid && rdata[7:2] == 6'h00 && !rdata[0]) else $error("control read shows bits");
	a_bank_noread: assert property (rd && addr == `ADDR_DATA_BANK_SELECT |=>
		!rvalid || rdata == 8'h00) else $error("bank register readable");
	a_answer_cause: assert property (rvalid |-> $past(rd) || $past(rd, 2))
		else $error("read answer without request");
	a_busy_hold: assert property ($fell(prog_busy) |->
		busy_len >= PROG - 2 && busy_len <= PROG + 2) else $error("busy length wrong");
	a_no_enable: assert property (wr && addr <= `WINDOW_TOP && !en_seen && !prog_busy
		&& !$past(wr) |=> !prog_busy [*3]) else $error("programming without enable");
	a_start_needs: assert property (wr && addr == `ADDR_EEPROM_CONTROL && wdata[3]
		&& !wdata[0] && !prog_busy |=> !prog_busy [*3]) else $error("start without enable");
endmodule : bank_eeprom_checker

// ---- bench/tb_top.sv ----
/* Testbench driving the software port of the CPU end.
 * Assumes both design ends and a derived-data model of the paged arrays. */
`timescale 1ns/10ps
`include "bank_eeprom_consts.svh"
module tb_top;
	logic       clk;
	logic       rst_n;
	logic [7:0] sw_addr;
	logic [7:0] sw_wdata;
	logic       sw_wr;
	logic       sw_rd;
	logic [7:0] page_rdata;
	logic [3:0] page_sel;
	logic [5:0] page_addr;
	logic       page_wr;
	logic       prog_busy;
	logic [7:0] page_wdata;
	logic       page_rd;
	logic [7:0] sw_rdata;
	logic [7:0] bank_copy;
	logic [7:0] ctl_copy;
	int         miscompares;
	int         tests_run;
	logic [7:0] codes [4] = '{8'h08, 8'h10, 8'h20, 8'h40};
	data_bus_if bus ();
	bank_eeprom_dev bank_eeprom_dev_inst (.clk(clk), .rst_n(rst_n), .bus(bus),
		.page_sel(page_sel), .page_addr(page_addr), .page_wdata(page_wdata),
		.page_wr(page_wr), .page_rd(page_rd), .page_rdata(page_rdata),
		.prog_busy(prog_busy));
	bank_eeprom_cpu bank_eeprom_cpu_inst (.clk(clk), .rst_n(rst_n), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
		.bank_copy(bank_copy), .ctl_copy(ctl_copy), .bus(bus));
	bank_eeprom_checker bank_eeprom_checker_inst (.clk(clk), .rst_n(rst_n),
		.addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata),
		.rvalid(bus.rvalid), .page_sel(page_sel), .page_addr(page_addr),
		.page_wdata(page_wdata), .page_wr(page_wr), .page_rd(page_rd),
		.prog_busy(prog_busy));
	// Arrays answer with data derived from page and offset, so a misroute shows
	assign page_rdata = {page_sel, page_addr[3:0]};
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic wrap_up;
		$display("Compares %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check8
	task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sw_addr  <= a;
		sw_wdata <= d;
		sw_wr    <= 1'b1;
		@(posedge clk);
		sw_wr    <= 1'b0;
	endtask : sw_write
	// Without want, the read is only issued and its answer ignored
	task automatic sw_read(input logic [7:0] a, input logic [7:0] exp, input bit want);
		int n;
		@(posedge clk);
		sw_addr <= a;
		sw_rd   <= 1'b1;
		@(posedge clk);
		sw_rd   <= 1'b0;
		#1;
		n = 0;
		while (want && bus.rvalid !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (want && bus.rvalid !== 1'b1) begin
			miscompares++;
			$display("ERROR %0t no read answer", $time);
			wrap_up();
		end
		if (want) begin
			check8(bus.rdata, exp);
			@(posedge clk);
			#1;
			check8(sw_rdata, exp);
		end
		repeat (2) @(posedge clk);
	endtask : sw_read
	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		#1;
		while (prog_busy !== lvl && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		check8({7'h00, prog_busy}, {7'h00, lvl});
		if (n == 3000)
			wrap_up();
	endtask : wait_busy
	task automatic program_wait;
		wait_busy(1'b1);
		wait_busy(1'b0);
	endtask : program_wait
	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rst_n       = 1'b0;
		sw_addr     = 8'h00;
		sw_wdata    = 8'h00;
		sw_wr       = 1'b0;
		sw_rd       = 1'b0;
		miscompares = 0;
		tests_run   = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		sw_read(`ADDR_EEPROM_CONTROL, `CTL_RESET, 1);
		foreach (codes[i]) begin
			sw_write(`ADDR_DATA_BANK_SELECT, codes[i]);
			sw_read(8'h2a, {codes[i][6:3], 4'ha}, 1);
			check8(bank_copy, codes[i]);
			sw_write(8'h2a, codes[i]);
		end
		sw_read(`ADDR_DATA_BANK_SELECT, 8'h00, 0);
		sw_write(`ADDR_DATA_BANK_SELECT, 8'h01);
		sw_write(`ADDR_EEPROM_CONTROL, 8'h01);
		sw_write(8'h05, 8'ha5);
		wait_busy(1'b1);
		sw_read(`ADDR_EEPROM_CONTROL, 8'h02, 1);
		sw_write(`ADDR_EEPROM_CONTROL, 8'h40);
		wait_busy(1'b0);
		sw_read(8'h05, 8'ha5, 1);
		sw_write(`ADDR_EEPROM_CONTROL, 8'h00);
		sw_write(8'h05, 8'h3c);
		sw_read(8'h05, 8'ha5, 1);
		sw_write(`ADDR_EEPROM_CONTROL, 8'h05);
		sw_write(8'h00, 8'h11);
		sw_write(8'h02, 8'h22);
		sw_write(8'h0d, 8'h99);
		sw_write(`ADDR_EEPROM_CONTROL, 8'h0d);
		program_wait();
		sw_read(8'h00, 8'h11, 1);
		sw_read(8'h02, 8'h22, 1);
		sw_read(8'h05, 8'ha5, 1);
		sw_write(8'h01, 8'h5a);
		program_wait();
		sw_read(8'h01, 8'h5a, 1);
		sw_write(`ADDR_EEPROM_CONTROL, 8'h05);
		sw_write(8'h00, 8'h77);
		sw_write(`ADDR_EEPROM_CONTROL, 8'h01);
		sw_write(`ADDR_EEPROM_CONTROL, 8'h09);
		sw_read(`ADDR_EEPROM_CONTROL, 8'h00, 1);
		sw_read(8'h00, 8'h11, 1);
		sw_write(`ADDR_EEPROM_CONTROL, 8'h08);
		sw_write(`ADDR_DATA_BANK_SELECT, 8'h02);
		sw_write(`ADDR_EEPROM_CONTROL, 8'h01);
		sw_write(8'h05, 8'hc3);
		program_wait();
		sw_read(8'h05, 8'hc3, 1);
		// Two bank bits asked for: only the lowest, page 0, may pass
		sw_write(`ADDR_DATA_BANK_SELECT, 8'h03);
		sw_read(8'h05, 8'ha5, 1);
		check8(bank_copy, 8'h01);
		// Standby with enable set must neither program nor show busy
		sw_write(`ADDR_EEPROM_CONTROL, 8'h71);
		sw_write(8'h05, 8'h66);
		sw_read(`ADDR_EEPROM_CONTROL, 8'h00, 1);
		check8(ctl_copy, 8'h41);
		sw_write(`ADDR_EEPROM_CONTROL, 8'h00);
		sw_read(8'h05, 8'ha5, 1);
		wrap_up();
	end
endmodule : tb_top
